// File: logic/shhc_top.sv
// Purpose: Two-zone heater supervisor for a heated sonic anemometer head.
// Assumes: Sensor samples and diagnostic strobes arrive from logic on clk_sys.
// Notes: Heater outputs are drive levels; zero means the zone is off.
`timescale 1ns/1ps
`default_nettype none
module shhc_top #(
	parameter int unsigned SEC_CYCLES = shhc_pkg::SEC_CYCLES,
	parameter int unsigned FLAG_WIN_S = shhc_pkg::FLAG_WIN_S,
	parameter int unsigned DEICE_STEP_S = shhc_pkg::DEICE_STEP_S
) (
	input  wire logic         clk_sys,
	input  wire logic         sys_rst,
	input  wire shhc_pkg::shhc_sense_t sense,
	input  wire logic         diag_stb,
	input  wire logic         diag_flag,
	output shhc_pkg::shhc_heat_t heat,
	output shhc_pkg::shhc_stat_t stat
);

	typedef struct packed {
		logic [23:0]          sec_cnt;
		logic [11:0]          step_cnt;
		shhc_pkg::shhc_temp_t amb;
		shhc_pkg::shhc_temp_t dew;
		shhc_pkg::shhc_temp_t arm;
		shhc_pkg::shhc_temp_t xdcr;
		shhc_pkg::shhc_lvl_t  deice_lvl;
		shhc_pkg::shhc_heat_t heat;
		shhc_pkg::shhc_stat_t stat;
	} shhc_top_state_t;

	localparam logic [23:0] SEC_LAST  = 24'(SEC_CYCLES - 1);
	localparam logic [11:0] STEP_LAST = 12'(DEICE_STEP_S - 1);

	// The spread needs one bit more than a reading so the difference cannot wrap.
	localparam int TEMP_SPAN = shhc_pkg::TEMP_W + 1;

	shhc_top_state_t s_r;
	shhc_top_state_t s_nxt;
	logic            sec_tick;
	logic            win_done;
	logic            rate_high;
	logic            rate_low;
	logic            hot;
	logic            spread_bad;
	logic signed [TEMP_SPAN-1:0] spread;

	assign sec_tick = (s_r.sec_cnt == SEC_LAST);

	shhc_flag_window #(
		.WIN_S (FLAG_WIN_S),
		.CNT_W (16)
	) u_win (
		.clk_sys   (clk_sys),
		.sys_rst   (sys_rst),
		.sec_tick  (sec_tick),
		.diag_stb  (diag_stb),
		.diag_flag (diag_flag),
		.win_done  (win_done),
		.rate_high (rate_high),
		.rate_low  (rate_low)
	);

	// Nudges one zone by a single step toward keeping its sensor just above
	// the dew point, but never lets it climb once the heating cap is met.
	function automatic shhc_pkg::shhc_lvl_t shhc_regulate(
		input shhc_pkg::shhc_lvl_t  lvl,
		input shhc_pkg::shhc_temp_t temp,
		input shhc_pkg::shhc_temp_t dew
	);
		logic signed [TEMP_SPAN-1:0] target;
		target = TEMP_SPAN'(dew) + TEMP_SPAN'(shhc_pkg::DEW_MARGIN);
		if (temp >= shhc_pkg::HEAT_CAP || TEMP_SPAN'(temp) > target)
			shhc_regulate = (lvl == shhc_pkg::LVL_ZERO) ? lvl : lvl - shhc_pkg::LVL_ONE;
		else
			shhc_regulate = (lvl == shhc_pkg::LVL_MAX) ? lvl : lvl + shhc_pkg::LVL_ONE;
	endfunction

	// The de-icing level is applied unless the zone is already at the cap.
	function automatic shhc_pkg::shhc_lvl_t shhc_capped(
		input shhc_pkg::shhc_lvl_t  lvl,
		input shhc_pkg::shhc_lvl_t  want,
		input shhc_pkg::shhc_temp_t temp
	);
		if (temp >= shhc_pkg::HEAT_CAP)
			shhc_capped = (lvl == shhc_pkg::LVL_ZERO) ? lvl : lvl - shhc_pkg::LVL_ONE;
		else
			shhc_capped = want;
	endfunction

	always_comb begin
		s_nxt = s_r;
		s_nxt.stat.fail_evt = 1'b0;
		s_nxt.sec_cnt = sec_tick ? '0 : s_r.sec_cnt + 24'h000001;
		if (sense.valid) begin
			s_nxt.amb  = sense.amb;
			s_nxt.dew  = sense.dew;
			s_nxt.arm  = sense.arm;
			s_nxt.xdcr = sense.xdcr;
		end
		hot = s_r.arm > shhc_pkg::SHUTDOWN_LIM || s_r.xdcr > shhc_pkg::SHUTDOWN_LIM;
		spread = TEMP_SPAN'(s_r.arm) - TEMP_SPAN'(s_r.xdcr);
		if (spread < 0)
			spread = -spread;
		spread_bad = spread > TEMP_SPAN'(shhc_pkg::FAIL_DELTA);
		s_nxt.stat.overtemp = hot;

		unique case (s_r.stat.mode)
			shhc_pkg::SHHC_HALT: begin
				// Stays here until reset even if the readings converge.
				s_nxt.stat.fail_halt = 1'b1;
			end
			shhc_pkg::SHHC_IDLE: begin
				s_nxt.heat = '0;
				if (win_done && rate_high) begin
					s_nxt.stat.mode = shhc_pkg::SHHC_DEICE;
					s_nxt.step_cnt = '0;
					s_nxt.deice_lvl = s_r.heat.zone2;
				end else if (s_r.amb < shhc_pkg::FROST_AMB_LIM)
					s_nxt.stat.mode = shhc_pkg::SHHC_FROST;
			end
			shhc_pkg::SHHC_FROST: begin
				if (win_done && rate_high) begin
					s_nxt.stat.mode = shhc_pkg::SHHC_DEICE;
					s_nxt.step_cnt = '0;
					s_nxt.deice_lvl = s_r.heat.zone2;
				end else if (s_r.amb >= shhc_pkg::FROST_AMB_LIM)
					s_nxt.stat.mode = shhc_pkg::SHHC_IDLE;
				else if (sec_tick) begin
					s_nxt.heat.zone1 = shhc_regulate(s_r.heat.zone1, s_r.arm, s_r.dew);
					s_nxt.heat.zone2 = shhc_regulate(s_r.heat.zone2, s_r.xdcr, s_r.dew);
				end
			end
			shhc_pkg::SHHC_DEICE: begin
				if (win_done && rate_low)
					s_nxt.stat.mode = shhc_pkg::SHHC_FROST;
				else if (sec_tick) begin
					if (s_r.step_cnt == STEP_LAST) begin
						s_nxt.step_cnt = '0;
						if (s_r.deice_lvl != shhc_pkg::LVL_MAX)
							s_nxt.deice_lvl = s_r.deice_lvl + shhc_pkg::LVL_ONE;
					end else
						s_nxt.step_cnt = s_r.step_cnt + 12'h001;
					s_nxt.heat.zone1 = shhc_capped(s_r.heat.zone1, s_r.deice_lvl, s_r.arm);
					s_nxt.heat.zone2 = shhc_capped(s_r.heat.zone2, s_r.deice_lvl, s_r.xdcr);
				end
			end
		endcase

		if (s_r.stat.mode != shhc_pkg::SHHC_HALT && spread_bad) begin
			s_nxt.stat.mode = shhc_pkg::SHHC_HALT;
			s_nxt.stat.fail_halt = 1'b1;
			s_nxt.stat.fail_evt = 1'b1;
		end
		// Shutdown overrides every mode; frost regulation restarts from zero afterwards, de-icing resumes at deice_lvl.
		if (hot || spread_bad || s_r.stat.mode == shhc_pkg::SHHC_HALT)
			s_nxt.heat = '0;
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign heat = s_r.heat;
	assign stat = s_r.stat;

endmodule // shhc_top
`default_nettype wire

// File: include/shhc_pkg.sv
// Purpose: Shared constants and types for the sonic head heater supervisor.
// Assumes: Temperatures are signed 12-bit values in units of 1/16 degC.
// Notes: Timing figures are kept in their own units; cycle counts derive from them.
// Functional notes
// - Drive two heater zones: arms/strut zone 1, transducer fingers zone 2.
// - Frost mode below 2 degC ambient keeps transducers above dew point.
// - Enter de-icing when diagnostic flag share over 60 s exceeds 25 percent.
// - In de-icing raise heater level one step every 15 minutes.
// - Flag share below 25 percent clears blockage, back to frost mode.
// - Never heat transducer or arm above 38 degC.
// - Any head temperature above 45 degC switches all heaters off.
// - Arm/transducer spread above 15 degC is a failure: heaters off, halt.
package shhc_pkg;

	localparam int unsigned CLK_FREQ_HZ  = 10_000_000;
	localparam int unsigned TICK_PERIOD_S = 1;
	localparam int unsigned SEC_CYCLES   = CLK_FREQ_HZ * TICK_PERIOD_S;
	localparam int unsigned FLAG_WIN_S   = 60;
	localparam int unsigned DEICE_STEP_MIN = 15;
	localparam int unsigned DEICE_STEP_S = DEICE_STEP_MIN * 60;
	localparam int unsigned FLAG_PCT     = 25;
	localparam int unsigned FLAG_SCALE   = 100 / FLAG_PCT;

	localparam int TEMP_W = 12;
	localparam int LVL_W  = 8;

	typedef logic signed [TEMP_W-1:0] shhc_temp_t;
	typedef logic [LVL_W-1:0]         shhc_lvl_t;

	localparam shhc_temp_t FROST_AMB_LIM = 12'sh020;
	localparam shhc_temp_t HEAT_CAP      = 12'sh260;
	localparam shhc_temp_t SHUTDOWN_LIM  = 12'sh2D0;
	localparam shhc_temp_t FAIL_DELTA    = 12'sh0F0;
	localparam shhc_temp_t DEW_MARGIN    = 12'sh010;
	localparam shhc_lvl_t  LVL_MAX       = 8'hFF;
	localparam shhc_lvl_t  LVL_ZERO      = 8'h00;
	localparam shhc_lvl_t  LVL_ONE       = 8'h01;

	typedef enum logic [1:0] {
		SHHC_IDLE,
		SHHC_FROST,
		SHHC_DEICE,
		SHHC_HALT
	} shhc_mode_t;

	typedef struct packed {
		shhc_temp_t amb;
		shhc_temp_t dew;
		shhc_temp_t arm;
		shhc_temp_t xdcr;
		logic       valid;
	} shhc_sense_t;

	typedef struct packed {
		shhc_lvl_t zone1;
		shhc_lvl_t zone2;
	} shhc_heat_t;

	typedef struct packed {
		shhc_mode_t mode;
		logic       overtemp;
		logic       fail_halt;
		logic       fail_evt;
	} shhc_stat_t;

endpackage

// File: logic/shhc_flag_window.sv
// Purpose: Measures the share of flagged anemometer samples over a fixed window.
// Assumes: Diagnostic strobes come from logic on clk_sys; sec_tick is a one-cycle enable.
// Notes: Counters saturate, so a very long window judges only its first samples.
`timescale 1ns/1ps
`default_nettype none
module shhc_flag_window #(
	parameter int unsigned WIN_S = shhc_pkg::FLAG_WIN_S,
	parameter int CNT_W = 16
) (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic sec_tick,
	input  wire logic diag_stb,
	input  wire logic diag_flag,
	output logic      win_done,
	output logic      rate_high,
	output logic      rate_low
);

	typedef struct packed {
		logic [7:0]       sec_cnt;
		logic [CNT_W-1:0] n_samp;
		logic [CNT_W-1:0] n_flag;
		logic             done;
		logic             hi;
		logic             lo;
	} shhc_win_state_t;

	localparam logic [7:0]       WIN_LAST = 8'(WIN_S - 1);
	localparam logic [CNT_W-1:0] CNT_MAX  = '1;

	shhc_win_state_t s_r;
	shhc_win_state_t s_nxt;
	logic [CNT_W+1:0] flag_scaled;
	logic [CNT_W+1:0] samp_wide;

	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		flag_scaled = (CNT_W+2)'(s_r.n_flag) * (CNT_W+2)'(shhc_pkg::FLAG_SCALE);
		samp_wide = (CNT_W+2)'(s_r.n_samp);
		if (diag_stb && s_r.n_samp != CNT_MAX) begin
			s_nxt.n_samp = s_r.n_samp + 1'b1;
			if (diag_flag)
				s_nxt.n_flag = s_r.n_flag + 1'b1;
		end
		if (sec_tick) begin
			if (s_r.sec_cnt == WIN_LAST) begin
				s_nxt.sec_cnt = '0;
				s_nxt.done = 1'b1;
				s_nxt.hi = flag_scaled > samp_wide;
				s_nxt.lo = flag_scaled < samp_wide;
				// A sample landing on the window edge opens the next window.
				s_nxt.n_samp = CNT_W'(diag_stb);
				s_nxt.n_flag = CNT_W'(diag_stb & diag_flag);
			end else begin
				s_nxt.sec_cnt = s_r.sec_cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign win_done  = s_r.done;
	assign rate_high = s_r.hi;
	assign rate_low  = s_r.lo;

endmodule // shhc_flag_window
`default_nettype wire

// File: test/shhc_probe_model.sv
// Purpose: Probe, head sensor and diagnostic stream model.
// Assumes: The bench sets the readings; a sample goes out every fourth cycle.
// Notes: flag_on gives a half-flagged stream, well above the de-icing share.
`timescale 1ns/1ps
`default_nettype none
module shhc_probe_model (
	input  wire logic                  clk_sys,
	input  wire shhc_pkg::shhc_sense_t rd,
	input  wire logic                  flag_on,
	output shhc_pkg::shhc_sense_t      sense,
	output logic                       diag_stb,
	output logic                       diag_flag
);
	logic [1:0] ph_r = 2'h0;
	initial begin
		sense = '0;
		diag_stb = 1'b0;
		diag_flag = 1'b0;
	end
	always @(posedge clk_sys) begin
		ph_r <= #1 ph_r + 2'h1;
		sense <= #1 {rd[48:1], ph_r == 2'h3};
		diag_stb <= #1 1'b1;
		diag_flag <= #1 flag_on & ph_r[0];
	end
endmodule // shhc_probe_model
`default_nettype wire

// File: test/shhc_top_chk.sv
// Purpose: Port-level checks of the heater supervisor.
// Assumes: One clock domain; reset is asynchronous and active high.
// Notes: Sample-driven checks skip samples taken while halted.
`timescale 1ns/1ps
`default_nettype none
module shhc_top_chk #(
	parameter int unsigned SEC_CYCLES   = shhc_pkg::SEC_CYCLES,
	parameter int unsigned FLAG_WIN_S   = shhc_pkg::FLAG_WIN_S,
	parameter int unsigned DEICE_STEP_S = shhc_pkg::DEICE_STEP_S
) (
	input wire logic                  clk_sys,
	input wire logic                  sys_rst,
	input wire shhc_pkg::shhc_sense_t sense,
	input wire logic                  diag_stb,
	input wire logic                  diag_flag,
	input wire shhc_pkg::shhc_heat_t  heat,
	input wire shhc_pkg::shhc_stat_t  stat
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	logic signed [12:0] gap;
	logic               wide;
	assign gap = sense.arm - sense.xdcr;
	assign wide = gap > 13'sd240 || gap < -13'sd240;
	sequence hot_in;
		sense.valid && !stat.fail_halt && !wide &&
		(sense.arm > shhc_pkg::SHUTDOWN_LIM || sense.xdcr > shhc_pkg::SHUTDOWN_LIM);
	endsequence
	sequence split_in;
		sense.valid && !stat.fail_halt && wide;
	endsequence
	a_hot_cut: assert property (hot_in |-> ##2 (stat.overtemp && heat == '0))
		else $error("overtemp did not cut heaters");
	a_hot_zero: assert property (stat.overtemp |-> heat == '0)
		else $error("heat on during overtemp");
	a_split_halt: assert property (split_in |-> ##2 stat.fail_halt)
		else $error("spread did not halt");
	a_split_evt: assert property (split_in |-> ##2 stat.fail_evt)
		else $error("failure event missing");
	a_halt_off: assert property (stat.fail_halt |=> heat == '0)
		else $error("heat on while halted");
	a_halt_stays: assert property (stat.fail_halt |=> stat.fail_halt && stat.mode == shhc_pkg::SHHC_HALT)
		else $error("halt released");
	a_evt_pulse: assert property (stat.fail_evt |=> !stat.fail_evt)
		else $error("failure event too long");
	a_idle_off: assert property (stat.mode == shhc_pkg::SHHC_IDLE [*2] |-> heat == '0)
		else $error("heat on in idle");
	a_deice_step: assert property ((stat.mode == shhc_pkg::SHHC_DEICE && !stat.overtemp &&
		$past(stat.mode) == shhc_pkg::SHHC_DEICE) |-> heat.zone2 <= $past(heat.zone2) + 1)
		else $error("de-icing step above one");
endmodule // shhc_top_chk
bind shhc_top shhc_top_chk #(.SEC_CYCLES(SEC_CYCLES), .FLAG_WIN_S(FLAG_WIN_S),
	.DEICE_STEP_S(DEICE_STEP_S)) u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .sense(sense),
	.diag_stb(diag_stb), .diag_flag(diag_flag), .heat(heat), .stat(stat));
`default_nettype wire

// File: test/tb_shhc_top.sv
// Purpose: Self-checking bench for the heater supervisor.
// Assumes: Ten cycles a second, a 3 s flag window and a 4 s de-icing step.
// Notes: Waits are whole seconds; those of 1 s and 2 s are shorter than a full window.
`timescale 1ns/1ps
`default_nettype none
module tb_shhc_top;
	logic                  clk_sys = 1'b0;
	logic                  sys_rst = 1'b1;
	logic                  flag_on = 1'b0;
	int                    errors = 0;
	int                    check_count = 0;
	shhc_pkg::shhc_sense_t rd = '0;
	shhc_pkg::shhc_sense_t sense;
	logic                  diag_stb;
	logic                  diag_flag;
	shhc_pkg::shhc_heat_t  heat;
	shhc_pkg::shhc_stat_t  stat;
	shhc_pkg::shhc_lvl_t   z0;
	always #50 clk_sys = ~clk_sys;
	shhc_probe_model u_probe (.clk_sys(clk_sys), .rd(rd), .flag_on(flag_on), .sense(sense),
		.diag_stb(diag_stb), .diag_flag(diag_flag));
	shhc_top #(.SEC_CYCLES(10), .FLAG_WIN_S(3), .DEICE_STEP_S(4)) dut (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .sense(sense), .diag_stb(diag_stb), .diag_flag(diag_flag),
		.heat(heat), .stat(stat));
	task automatic print_verdict();
		if (errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic secs(input int s);
		repeat (s * 10) @(posedge clk_sys);
		#1;
	endtask
	task automatic put(input logic [11:0] a, d, r, x);
		@(posedge clk_sys);
		#1 rd = {a, d, r, x, 1'b0};
	endtask
	task automatic rst();
		sys_rst = 1'b1;
		repeat (3) @(posedge clk_sys);
		#1 sys_rst = 1'b0;
	endtask
	task automatic t_frost();
		put(12'h000, 12'h080, 12'h040, 12'h040);
		secs(4);
		chk("mode", shhc_pkg::SHHC_FROST, stat.mode);
		chk("zone1 on", 8'h01, heat.zone1 != 8'h00);
		chk("zone2 on", 8'h01, heat.zone2 != 8'h00);
		z0 = heat.zone2;
		put(12'h000, 12'h280, 12'h260, 12'h260);
		secs(2);
		chk("zone2 eases", 8'h01, heat.zone2 < z0);
	endtask
	task automatic t_deice();
		put(12'h000, 12'h080, 12'h040, 12'h040);
		flag_on = 1'b1;
		secs(7);
		chk("mode", shhc_pkg::SHHC_DEICE, stat.mode);
		z0 = heat.zone2;
		secs(9);
		chk("zone2 rises", 8'h01, heat.zone2 > z0);
		flag_on = 1'b0;
		secs(7);
		chk("mode", shhc_pkg::SHHC_FROST, stat.mode);
	endtask
	task automatic t_idle();
		put(12'h020, 12'h000, 12'h040, 12'h040);
		secs(2);
		chk("mode", shhc_pkg::SHHC_IDLE, stat.mode);
		chk("heat off", 8'h01, heat == '0);
	endtask
	task automatic t_hot();
		put(12'h000, 12'h080, 12'h2D0, 12'h2D0);
		secs(1);
		chk("overtemp", 8'h00, stat.overtemp);
		put(12'h000, 12'h080, 12'h2D1, 12'h2D0);
		secs(1);
		chk("overtemp", 8'h01, stat.overtemp);
		chk("heat off", 8'h01, heat == '0);
	endtask
	task automatic t_fail();
		put(12'h000, 12'h080, 12'h0F0, 12'h000);
		secs(1);
		chk("halt", 8'h00, stat.fail_halt);
		put(12'h000, 12'h080, 12'h100, 12'h000);
		secs(1);
		chk("mode", shhc_pkg::SHHC_HALT, stat.mode);
		chk("heat off", 8'h01, heat == '0);
		put(12'h000, 12'h080, 12'h040, 12'h040);
		secs(2);
		chk("halt", 8'h01, stat.fail_halt);
		rst();
		chk("halt", 8'h00, stat.fail_halt);
	endtask
	initial begin
		rst();
		t_frost();
		t_deice();
		t_idle();
		t_hot();
		t_fail();
		print_verdict();
	end
endmodule // tb_shhc_top
`default_nettype wire
